// File: rtl/tc_timer.sv
`timescale 1ns/1ps
`default_nettype none

module tc_timer (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic ext_count_pin,
    input wire logic sleep_mode,
    input wire logic watchdog_clear_instr,
    input wire logic watchdog_raw_tick,
    output logic watchdog_tick,
    output logic overflow_irq
);

    // registered and next state
    tc_pkg::tc_state_s st;
    tc_pkg::tc_state_s next_st;

    // decoded strobes
    logic wr_count;
    logic wr_intctl;
    logic wr_option;
    // phase decodes
    logic is_q2;
    logic is_q4;
    // option fields
    logic clk_src;
    logic edge_sel;
    logic pre_assign;
    logic [2:0] rate_sel;
    // polarity-corrected pin level and its edge
    logic pol_level;
    logic pol_edge;
    // prescaler output level seen by the sampler
    logic pre_level;
    // sampled external event
    logic ext_evt;
    // prescaler completes a period on this step
    logic pre_full;
    // counter advances this cycle
    logic inc;

    // mask of prescaler bits that must be all ones at period end
    function automatic logic [7:0] rate_mask(input logic [2:0] rate, input logic for_timer);
        logic [8:0] m;
        m = for_timer ? ((9'h002 << rate) - 9'h001) : ((9'h001 << rate) - 9'h001);
        return m[7:0];
    endfunction

    // same-cycle address decode; one function serves all three registers
    function automatic logic hit(input logic [8:0] a, input logic [8:0] target);
        return a == target;
    endfunction

    assign wr_count = reg_wr && hit(reg_addr, tc_pkg::ADDR_COUNT);
    assign wr_intctl = reg_wr && hit(reg_addr, tc_pkg::ADDR_INTCTL);
    assign wr_option = reg_wr && hit(reg_addr, tc_pkg::ADDR_OPTION);
    assign is_q2 = st.phase == tc_pkg::PH_Q2;
    assign is_q4 = st.phase == tc_pkg::PH_Q4;
    assign clk_src = st.option[tc_pkg::BIT_CLK_SRC];
    assign edge_sel = st.option[tc_pkg::BIT_EDGE_SEL];
    assign pre_assign = st.option[tc_pkg::BIT_PRE_ASSIGN];
    assign rate_sel = st.option[tc_pkg::BIT_RATE_HI:0];

    // outputs straight from flip-flops
    assign reg_rdata = st.rdata;
    assign overflow_irq = st.irq;
    assign watchdog_tick = st.wdt_tick;

    // event detection on the pin and the prescaler output
    always_comb
    begin
        // inverting both levels turns a falling edge into a rising one
        pol_level = st.ext_s ^ edge_sel;
        pol_edge = pol_level && !(st.ext_prev ^ edge_sel);
        // unassigned prescaler is a plain wire for the pin
        if (pre_assign)
        begin
            pre_level = pol_level;
        end
        else
        begin
            pre_level = st.pre[rate_sel];
        end
        // a new high sample after a low one on q2 or q4
        ext_evt = (is_q2 || is_q4) && pre_level && !st.samp;
        // period end for whichever user holds the prescaler
        pre_full = (st.pre & rate_mask(rate_sel, !pre_assign))
            == rate_mask(rate_sel, !pre_assign);
    end

    // next-state logic
    always_comb
    begin
        next_st = st;
        inc = 1'b0;

        // phase sequencer, runs through sleep so the bus stays alive
        case (st.phase)
            tc_pkg::PH_Q1: next_st.phase = tc_pkg::PH_Q2;
            tc_pkg::PH_Q2: next_st.phase = tc_pkg::PH_Q3;
            tc_pkg::PH_Q3: next_st.phase = tc_pkg::PH_Q4;
            tc_pkg::PH_Q4: next_st.phase = tc_pkg::PH_Q1;
            default: next_st.phase = tc_pkg::PH_Q1;
        endcase

        // two-stage synchroniser, then edge history
        next_st.ext_m = ext_count_pin;
        next_st.ext_s = st.ext_m;
        next_st.ext_prev = st.ext_s;

        // sample the prescaler output only on q2 and q4
        if (is_q2 || is_q4)
        begin
            next_st.samp = pre_level;
        end

        // write hold counts down at the end of each instruction cycle
        if (is_q4 && st.hold != 2'h0)
        begin
            next_st.hold = st.hold - 2'h1;
        end

        // pick the counter's increment source
        if (clk_src)
        begin
            inc = ext_evt;
        end
        else if (pre_assign)
        begin
            inc = is_q4;
        end
        else
        begin
            inc = is_q4 && pre_full;
        end
        // the counter does not step while held off or asleep
        if (st.hold != 2'h0 || sleep_mode)
        begin
            inc = 1'b0;
        end

        // prescaler stepping for its current owner
        if (!pre_assign)
        begin
            // counter owns it; frozen in sleep with the rest of the timer
            if (!sleep_mode && (clk_src ? pol_edge : is_q4))
            begin
                next_st.pre = st.pre + 8'h01;
            end
            // watchdog ticks pass through unscaled
            next_st.wdt_tick = watchdog_raw_tick;
        end
        else
        begin
            // watchdog owns it; the watchdog keeps running in sleep
            if (watchdog_raw_tick)
            begin
                next_st.pre = st.pre + 8'h01;
            end
            next_st.wdt_tick = watchdog_raw_tick && pre_full;
            // clear instruction restarts the period
            if (watchdog_clear_instr)
            begin
                next_st.pre = tc_pkg::RST_PRE;
            end
        end

        // counter step and overflow
        if (inc)
        begin
            next_st.count = st.count + 8'h01;
        end

        // software writes; the count write wins over a step
        if (wr_count)
        begin
            next_st.count = reg_wdata;
            next_st.hold = tc_pkg::WR_HOLD_CYCLES;
            // the assignment bit is not touched here
            if (!pre_assign)
            begin
                next_st.pre = tc_pkg::RST_PRE;
            end
        end
        if (wr_intctl)
        begin
            next_st.ovf_ie = reg_wdata[tc_pkg::BIT_OVF_IE];
            next_st.ovf_flag = reg_wdata[tc_pkg::BIT_OVF_FLAG];
        end
        if (wr_option)
        begin
            // moving ownership is safe only with the software sequence
            next_st.option = reg_wdata;
        end

        // wrap sets the flag; set wins over a clearing write
        if (inc && st.count == 8'hFF && !wr_count)
        begin
            next_st.ovf_flag = 1'b1;
        end

        // request follows flag and enable with no extra lag
        next_st.irq = next_st.ovf_flag && next_st.ovf_ie;

        // read mux; data stand for exactly one cycle
        next_st.rdata = 8'h00;
        if (reg_rd)
        begin
            if (hit(reg_addr, tc_pkg::ADDR_COUNT))
            begin
                next_st.rdata = st.count;
            end
            else if (hit(reg_addr, tc_pkg::ADDR_INTCTL))
            begin
                next_st.rdata = 8'h00;
                next_st.rdata[tc_pkg::BIT_OVF_IE] = st.ovf_ie;
                next_st.rdata[tc_pkg::BIT_OVF_FLAG] = st.ovf_flag;
            end
            else if (hit(reg_addr, tc_pkg::ADDR_OPTION))
            begin
                next_st.rdata = st.option;
            end
            else
            begin
                // prescaler has no address of its own
                next_st.rdata = tc_pkg::RD_UNMAPPED;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st <= '0;
            st.phase <= tc_pkg::PH_Q1;
            st.count <= tc_pkg::RST_COUNT;
            st.option <= tc_pkg::RST_OPTION;
            st.pre <= tc_pkg::RST_PRE;
            // sample starts high: a quiet low pin under the falling-edge
            // reset select must not look like a fresh edge
            st.samp <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // internal source, unscaled: one step per q4
    a_timer_step: assert property (@(posedge clk_sys) disable iff (rst)
        (is_q4 && !clk_src && pre_assign && !sleep_mode && st.hold == 2'h0 && !wr_count)
        |=> st.count == $past(st.count) + 8'h01)
        else $error("timer did not step on instruction cycle");

    // written value holds through the hold window
    a_write_hold: assert property (@(posedge clk_sys) disable iff (rst)
        wr_count ##1 (!wr_count)[*7] |-> st.count == $past(reg_wdata, 7))
        else $error("count moved inside write hold window");

    // external mode moves only on a sampled event
    a_ext_only: assert property (@(posedge clk_sys) disable iff (rst)
        ($past(clk_src) && !$past(wr_count) && $changed(st.count)) |-> $past(ext_evt))
        else $error("external mode count moved without event");

    // unscaled sample follows polarity-corrected pin
    a_edge_pol: assert property (@(posedge clk_sys) disable iff (rst)
        ((is_q2 || is_q4) && pre_assign)
        |=> st.samp == ($past(st.ext_s) ^ $past(edge_sel)))
        else $error("sample ignores edge select");

    // wrap sets the flag
    a_ovf_set: assert property (@(posedge clk_sys) disable iff (rst)
        (st.count == 8'hFF && inc && !wr_count) |=> st.ovf_flag && st.count == 8'h00)
        else $error("wrap did not set overflow flag");

    // disabled enable keeps the request low
    a_irq_mask: assert property (@(posedge clk_sys) disable iff (rst)
        (!st.ovf_ie && !wr_intctl) |=> !overflow_irq)
        else $error("request raised while masked");

    // sleep freezes the counter
    a_sleep_stop: assert property (@(posedge clk_sys) disable iff (rst)
        (sleep_mode && !wr_count) |=> $stable(st.count))
        else $error("counter moved in sleep");

    // sampler holds outside q2 and q4
    a_samp_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (!is_q2 && !is_q4) |=> $stable(st.samp))
        else $error("sample changed outside q2 and q4");

    // watchdog unscaled while counter owns the prescaler
    a_wdt_pass: assert property (@(posedge clk_sys) disable iff (rst)
        (!pre_assign && watchdog_raw_tick) |=> watchdog_tick)
        else $error("watchdog tick lost while unscaled");

    // watchdog rate 1:1 at rate zero
    a_wdt_unity: assert property (@(posedge clk_sys) disable iff (rst)
        (pre_assign && rate_sel == 3'h0 && watchdog_raw_tick) |=> watchdog_tick)
        else $error("watchdog 1:1 rate not honoured");

    // count write clears prescaler, keeps assignment
    a_pre_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_count && !pre_assign && !wr_option)
        |=> st.pre == 8'h00 && !st.option[tc_pkg::BIT_PRE_ASSIGN])
        else $error("count write did not clear prescaler");

    // watchdog clear clears prescaler
    a_wdt_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (watchdog_clear_instr && pre_assign) |=> st.pre == 8'h00)
        else $error("watchdog clear left prescaler count");

    // count read hands back the count one cycle later
    a_count_read: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_rd && hit(reg_addr, tc_pkg::ADDR_COUNT)) |=> reg_rdata == $past(st.count))
        else $error("count read returned wrong value");

endmodule

`default_nettype wire

// File: rtl/tc_pkg.sv
// shared constants and carriers for the 8-bit timer/counter
`default_nettype none

package tc_pkg;

    // register data width
    localparam int DATA_W = 8;
    // register address width on the plain port
    localparam int ADDR_W = 9;

    // register offsets
    localparam logic [8:0] ADDR_COUNT = 9'h001;
    localparam logic [8:0] ADDR_INTCTL = 9'h00B;
    localparam logic [8:0] ADDR_OPTION = 9'h081;

    // option_config field positions
    localparam int BIT_CLK_SRC = 5;
    localparam int BIT_EDGE_SEL = 4;
    localparam int BIT_PRE_ASSIGN = 3;
    localparam int BIT_RATE_HI = 2;

    // interrupt_control_status field positions
    localparam int BIT_OVF_IE = 5;
    localparam int BIT_OVF_FLAG = 2;

    // reset values and the unmapped read value
    localparam logic [7:0] RST_OPTION = 8'hFF;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_PRE = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // instruction cycles that counting is held off after a count write
    localparam logic [1:0] WR_HOLD_CYCLES = 2'h2;

    // four internal phases make one instruction cycle
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} tc_phase_e;

    // complete state of the timer block
    typedef struct packed {
        tc_phase_e phase;      // current instruction-cycle phase
        logic [7:0] count;     // timer_count_value
        logic [7:0] option;    // option_config, all bits kept
        logic ovf_ie;          // overflow_int_enable
        logic ovf_flag;        // overflow_flag
        logic [7:0] pre;       // shared prescaler count, hidden
        logic [1:0] hold;      // instruction cycles left with counting held
        logic ext_m;           // synchroniser first stage
        logic ext_s;           // synchroniser second stage
        logic ext_prev;        // previous synchronised level
        logic samp;            // prescaler output sampled on q2/q4
        logic [7:0] rdata;     // read data register
        logic irq;             // overflow interrupt request
        logic wdt_tick;        // tick to the watchdog, scaled only when the watchdog owns the prescaler
    } tc_state_s;

endpackage

`default_nettype wire

// File: testbench/tc_count_src.sv
`timescale 1ns/1ps
`default_nettype none

// far-side source of the external count pin: toggles it n times on request
module tc_count_src (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic go,
    input wire logic [3:0] n,
    output logic pin,
    output logic busy
);
    logic [3:0] left; // toggles still to make
    logic [2:0] tmr; // cycles spent at the current level

    assign busy = (left != 4'h0);

    // each level lasts 8 cycles, so q2/q4 sampling cannot miss it
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pin <= 1'b0;
            left <= 4'h0;
            tmr <= 3'h0;
        end
        else if (go && !busy)
        begin
            left <= n;
            tmr <= 3'h0;
        end
        else if (busy)
        begin
            tmr <= tmr + 3'h1;
            // level held long enough for the sampler
            if (tmr == 3'h7)
            begin
                pin <= ~pin;
                left <= left - 4'h1;
            end
        end
    end
endmodule

`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) \
    begin \
        check_count++; \
        if ((gt) !== (ex)) \
        begin \
            bad_count++; \
            $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
        end \
    end

module testbench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic ext_count_pin;
    logic sleep_mode = 1'b0;
    logic wclr = 1'b0;
    logic wraw = 1'b0;
    logic wtick;
    logic irq;
    logic go = 1'b0;
    logic [3:0] n = 4'h0;
    logic busy;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    int wd_seen = 0;
    int s;
    logic [7:0] got;

    always #2.5 clk_sys = ~clk_sys;

    tc_timer DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_count_pin(ext_count_pin),
        .sleep_mode(sleep_mode), .watchdog_clear_instr(wclr), .watchdog_raw_tick(wraw),
        .watchdog_tick(wtick), .overflow_irq(irq));

    tc_count_src SRC (.clk_sys(clk_sys), .rst(rst), .go(go), .n(n), .pin(ext_count_pin),
        .busy(busy));

    // watchdog ticks seen so far, scaled or passed through
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (wtick === 1'b1)
            wd_seen <= wd_seen + 1;
        // hang guard, well above the expected run length
        if (cyc == 30000)
        begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge clk_sys);
    endtask

    // one-cycle write, then a gap so strobes never collide
    task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [8:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk_sys);
    endtask

    task automatic chk_reg(input string nm, input logic [8:0] a, input logic [7:0] ex);
        logic [7:0] d;
        rd_reg(a, d);
        `CHK(nm, ex, d)
    endtask

    task automatic toggles(input logic [3:0] k);
        n <= k;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 200 && busy === 1'b1; i++)
            @(posedge clk_sys);
        idle(16);
    endtask

    task automatic pulse_raw(input int k);
        repeat (k)
        begin
            wraw <= 1'b1;
            @(posedge clk_sys);
            wraw <= 1'b0;
            @(posedge clk_sys);
        end
    endtask

    task automatic pulse_clr;
        wclr <= 1'b1;
        @(posedge clk_sys);
        wclr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic t_reset;
        chk_reg("option", tc_pkg::ADDR_OPTION, 8'hFF);
        chk_reg("intctl", tc_pkg::ADDR_INTCTL, 8'h00);
        wr_reg(9'h055, 8'h5A);
        chk_reg("unmapped", 9'h055, 8'h00);
        chk_reg("count", tc_pkg::ADDR_COUNT, 8'h00);
        // keep the later scenarios on the same instruction-cycle phase
        idle(2);
        `CHK("irq", 1'b0, irq)
    endtask

    // internal source, watchdog owns the prescaler: one step per cycle of 4 clocks
    task automatic t_internal;
        wr_reg(tc_pkg::ADDR_OPTION, 8'h08);
        chk_reg("option", tc_pkg::ADDR_OPTION, 8'h08);
        wr_reg(tc_pkg::ADDR_COUNT, 8'h10);
        idle(39);
        chk_reg("count", tc_pkg::ADDR_COUNT, 8'h18);
    endtask

    task automatic t_overflow;
        wr_reg(tc_pkg::ADDR_COUNT, 8'hFE);
        idle(39);
        chk_reg("wrapped", tc_pkg::ADDR_COUNT, 8'h06);
        chk_reg("flag", tc_pkg::ADDR_INTCTL, 8'h04);
        `CHK("masked", 1'b0, irq)
        // flag cleared before the enable goes back on
        wr_reg(tc_pkg::ADDR_INTCTL, 8'h00);
        wr_reg(tc_pkg::ADDR_INTCTL, 8'h20);
        chk_reg("cleared", tc_pkg::ADDR_INTCTL, 8'h20);
        wr_reg(tc_pkg::ADDR_COUNT, 8'hFE);
        idle(39);
        chk_reg("flag on", tc_pkg::ADDR_INTCTL, 8'h24);
        `CHK("request", 1'b1, irq)
        wr_reg(tc_pkg::ADDR_INTCTL, 8'h00);
    endtask

    task automatic t_sleep;
        sleep_mode <= 1'b1;
        wr_reg(tc_pkg::ADDR_COUNT, 8'hFF);
        idle(80);
        chk_reg("asleep", tc_pkg::ADDR_COUNT, 8'hFF);
        chk_reg("no flag", tc_pkg::ADDR_INTCTL, 8'h00);
        sleep_mode <= 1'b0;
    endtask

    // window of 4R cycles: 3 or 4 steps, depending on hold vs prescaler
    task automatic t_prescale;
        for (int r = 0; r < 8; r++)
        begin
            wr_reg(tc_pkg::ADDR_OPTION, {5'h00, r[2:0]});
            wr_reg(tc_pkg::ADDR_COUNT, 8'h00);
            idle(16 * (2 << r) - 1);
            rd_reg(tc_pkg::ADDR_COUNT, got);
            // rate zero loses its first step inside the write hold
            `CHK("scaled", (r == 0) ? 8'h03 : 8'h04, got)
            chk_reg("assign kept", tc_pkg::ADDR_OPTION, {5'h00, r[2:0]});
        end
    endtask

    task automatic t_external;
        wr_reg(tc_pkg::ADDR_OPTION, 8'h28);
        wr_reg(tc_pkg::ADDR_COUNT, 8'h00);
        idle(16);
        toggles(4'h3);
        chk_reg("rising", tc_pkg::ADDR_COUNT, 8'h02);
        wr_reg(tc_pkg::ADDR_OPTION, 8'h38);
        wr_reg(tc_pkg::ADDR_COUNT, 8'h00);
        idle(16);
        toggles(4'h3);
        chk_reg("falling", tc_pkg::ADDR_COUNT, 8'h02);
        wr_reg(tc_pkg::ADDR_OPTION, 8'h20);
        wr_reg(tc_pkg::ADDR_COUNT, 8'h00);
        idle(16);
        toggles(4'h8);
        chk_reg("ext scaled", tc_pkg::ADDR_COUNT, 8'h02);
    endtask

    task automatic t_watchdog;
        // clear both sides before handing the prescaler over
        wr_reg(tc_pkg::ADDR_COUNT, 8'h00);
        pulse_clr();
        for (int r = 0; r < 8; r++)
        begin
            wr_reg(tc_pkg::ADDR_OPTION, {5'h01, r[2:0]});
            pulse_clr();
            s = wd_seen;
            pulse_raw(2 * (1 << r));
            idle(2);
            `CHK("wdt ratio", 2, wd_seen - s)
        end
        // 1:4, so a missed clear would tick on the second of the three pulses
        wr_reg(tc_pkg::ADDR_OPTION, 8'h0A);
        pulse_clr();
        pulse_raw(2);
        pulse_clr();
        s = wd_seen;
        pulse_raw(3);
        idle(2);
        `CHK("wdt cleared", 0, wd_seen - s)
        pulse_raw(1);
        idle(2);
        `CHK("wdt after clear", 1, wd_seen - s)
        wr_reg(tc_pkg::ADDR_OPTION, 8'h02);
        s = wd_seen;
        pulse_raw(5);
        idle(2);
        `CHK("wdt unscaled", 5, wd_seen - s)
    endtask

    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_internal();
        t_overflow();
        t_sleep();
        t_prescale();
        t_external();
        t_watchdog();
        test_done();
    end
endmodule

`default_nettype wire
